// ==== rtl/plmc_macrocells.sv ====
// Purpose: Eight configurable output macrocells with preload, protection bit and signature word.
// Assumes: One clock; synchronous active-low reset stands for power-up.
// Notes: The sum-of-products terms come in from the array as plain inputs.
// Behaviour
// - Combinatorial modes offer either output polarity, registered mode drives the inverted flip-flop.
// - Two fixed cells give no array feedback when set as plain combinatorial outputs.
// - All macrocell flip-flops start low after power-up.
// - A registered cell drives high right after power-up since its cleared flip-flop is inverted.
// - A combinatorial cell drives its logic value right after power-up with no forced level.
// - The flip-flops can be loaded directly from values supplied on the output pins.
// - Preload accepts any state, including states outside the designed sequence.
// - Once the protection bit is set, readback of the array pattern is refused.
// - The protection bit clears only through the erase input, which wins over a protect request in the same cycle.
// - A 64-bit user signature word holds any user data.
// - The signature word is readable whatever the protection bit holds.
`timescale 1ns/1ps
module plmc_macrocells
	import plmc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic global_select_lo_i,
	input wire logic global_select_hi_i,
	input wire logic [PLMC_CELLS-1:0] local_cell_select_i,
	input wire logic [PLMC_CELLS-1:0] polarity_high_i,
	input wire logic [PLMC_CELLS-1:0] sop_i,
	input wire logic [PLMC_CELLS-1:0] oe_term_i,
	input wire logic oe_n_i,
	input wire logic [PLMC_CELLS-1:0] pin_i,
	input wire logic preload_i,
	input wire logic erase_i,
	input wire logic prog_secure_i,
	input wire logic sig_write_i,
	input wire logic [PLMC_SIG_W-1:0] sig_data_i,
	input wire logic readback_req_i,
	input wire logic [PLMC_CELLS-1:0] array_pattern_i,
	output logic [PLMC_CELLS-1:0] pin_o,
	output logic [PLMC_CELLS-1:0] pin_oe_o,
	output logic [PLMC_CELLS-1:0] feedback_o,
	output logic [PLMC_CELLS-1:0] feedback_valid_o,
	output logic secure_o,
	output logic readback_valid_o,
	output logic [PLMC_CELLS-1:0] readback_data_o,
	output logic [PLMC_SIG_W-1:0] sig_o
);
	logic [PLMC_CELLS-1:0] ff_q, ff_d;
	logic [PLMC_CELLS-1:0] pin_q, pin_d, oe_q, oe_d, fb_q, fb_d, fbv_q, fbv_d;
	logic sec_q, sec_d, rbv_q, rbv_d;
	logic [PLMC_CELLS-1:0] rbd_q, rbd_d;
	logic [PLMC_SIG_W-1:0] sig_q, sig_d;
	logic [1:0] gsel;
	plmc_mode_t mode [PLMC_CELLS];
	// Which cells ran registered in the last cycle, kept only so the power-up level can be checked.
	logic [PLMC_CELLS-1:0] reg_cell_q, reg_cell_d;

	// The high select bit is the upper bit of the code, matching the package constants.
	assign gsel = {global_select_hi_i, global_select_lo_i};

	genvar gi;
	generate
		for (gi = 0; gi < PLMC_CELLS; gi++) begin : g_cell
			always_comb begin
				// One shared global code, one local bit per cell.
				// The spare global code falls back to input so no pin is driven by surprise.
				mode[gi] = PLMC_MODE_IN;
				if (gsel == PLMC_GSEL_REG) begin
					mode[gi] = local_cell_select_i[gi] ? PLMC_MODE_CIO : PLMC_MODE_REG;
				end else if (gsel == PLMC_GSEL_CMB) begin
					mode[gi] = local_cell_select_i[gi] ? PLMC_MODE_IN : PLMC_MODE_COUT;
				end else if (gsel == PLMC_GSEL_IO) begin
					mode[gi] = PLMC_MODE_CIO;
				end
			end

			always_comb begin
				ff_d[gi] = ff_q[gi];
				pin_d[gi] = 1'h0;
				oe_d[gi] = 1'h0;
				fb_d[gi] = 1'h0;
				fbv_d[gi] = 1'h1;
				reg_cell_d[gi] = (mode[gi] == PLMC_MODE_REG);
				// Power-up clears the flip-flop; the pins and the array only act outside reset.
				// Preload bypasses the array so any state, legal or not, can be forced.
				if (!rst_n_i) begin
					ff_d[gi] = PLMC_FF_RESET;
				end else if (preload_i) begin
					ff_d[gi] = pin_i[gi];
				end else if (mode[gi] == PLMC_MODE_REG) begin
					ff_d[gi] = sop_i[gi];
				end
				case (mode[gi])
					PLMC_MODE_REG: begin
						pin_d[gi] = ~ff_d[gi];
						oe_d[gi] = ~oe_n_i;
						fb_d[gi] = ff_d[gi];
					end
					PLMC_MODE_CIO: begin
						pin_d[gi] = polarity_high_i[gi] ? sop_i[gi] : ~sop_i[gi];
						oe_d[gi] = oe_term_i[gi];
						fb_d[gi] = pin_i[gi];
					end
					PLMC_MODE_COUT: begin
						pin_d[gi] = polarity_high_i[gi] ? sop_i[gi] : ~sop_i[gi];
						oe_d[gi] = 1'h1;
						// Blocked cells report a steady low with valid cleared, never a stale level.
						fb_d[gi] = PLMC_NOFB_MASK[gi] ? 1'h0 : pin_d[gi];
						fbv_d[gi] = ~PLMC_NOFB_MASK[gi];
					end
					PLMC_MODE_IN: begin
						oe_d[gi] = 1'h0;
						fb_d[gi] = pin_i[gi];
					end
					default: begin
						// Not reachable with a full decode; the buffer stays off if it ever is.
						oe_d[gi] = 1'h0;
					end
				endcase
			end
		end
	endgenerate

	always_comb begin
		sec_d = sec_q;
		sig_d = sig_q;
		// Erase is the only path that clears protection; programming may only set it.
		if (erase_i) begin
			sec_d = PLMC_SEC_CLEAR;
		end else if (prog_secure_i) begin
			sec_d = 1'h1;
		end
		if (sig_write_i) begin
			sig_d = sig_data_i;
		end
		rbv_d = readback_req_i && !sec_q;
		// Data is zero whenever readback is refused, so no part of the pattern leaks.
		rbd_d = rbv_d ? array_pattern_i : '0;
	end

	always_ff @(posedge clk_sys_i) begin
		// Cell registers take their power-up values through the next-state logic.
		ff_q <= ff_d;
		pin_q <= pin_d;
		oe_q <= oe_d;
		fb_q <= fb_d;
		fbv_q <= fbv_d;
		reg_cell_q <= reg_cell_d;
		if (!rst_n_i) begin
			rbv_q <= 1'h0;
			rbd_q <= '0;
		end else begin
			rbv_q <= rbv_d;
			rbd_q <= rbd_d;
		end
	end

	// The protection bit and signature are non-volatile: power-up does not touch them.
	always_ff @(posedge clk_sys_i) begin
		sec_q <= sec_d;
		sig_q <= sig_d;
	end

	assign pin_o = pin_q;
	assign pin_oe_o = oe_q;
	assign feedback_o = fb_q;
	assign feedback_valid_o = fbv_q;
	assign secure_o = sec_q;
	assign readback_valid_o = rbv_q;
	assign readback_data_o = rbd_q;
	assign sig_o = sig_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	reset_ff_low_a: assert property ($rose(rst_n_i) |-> ff_q == '0)
		else $error("Flip-flops not low after reset.");
	preload_load_a: assert property (preload_i |=> ff_q == $past(pin_i))
		else $error("Preload did not load pin values.");
	preload_any_a: assert property (preload_i && pin_i != sop_i |=> ff_q == $past(pin_i))
		else $error("Preload refused an arbitrary state.");
	secure_block_a: assert property (sec_q && readback_req_i |=> !readback_valid_o)
		else $error("Readback allowed while protected.");
	secure_hold_a: assert property (sec_q && !erase_i |=> sec_q)
		else $error("Protection bit cleared without erase.");
	erase_clear_a: assert property (erase_i |=> !secure_o)
		else $error("Erase did not clear protection.");
	sig_store_a: assert property (sig_write_i |=> sig_o == $past(sig_data_i))
		else $error("Signature word not stored.");
	sig_visible_a: assert property (!sig_write_i |=> $stable(sig_o))
		else $error("Signature changed without a write.");
	reg_invert_a: assert property (gsel == PLMC_GSEL_REG && !local_cell_select_i[0] && !preload_i
		|=> pin_o[0] == !$past(sop_i[0]))
		else $error("Registered output not inverted.");
	nofb_cell_a: assert property (gsel == PLMC_GSEL_CMB && !local_cell_select_i[3] |=> !feedback_valid_o[3])
		else $error("Feedback present on blocked cell.");
	input_off_a: assert property (gsel == PLMC_GSEL_CMB && local_cell_select_i[0] |=> !pin_oe_o[0])
		else $error("Dedicated input buffer enabled.");
	comb_follow_a: assert property (gsel == PLMC_GSEL_IO && polarity_high_i[1] |=> pin_o[1] == $past(sop_i[1]))
		else $error("Combinatorial output not following logic.");
	reset_reg_high_a: assert property ($rose(rst_n_i) |-> (pin_o | ~reg_cell_q) == '1)
		else $error("Registered output not high at power-up.");
	input_forward_a: assert property (gsel == PLMC_GSEL_CMB && local_cell_select_i[0] |=> feedback_o[0] == $past(pin_i[0]))
		else $error("Dedicated input not forwarded.");
	readback_ok_a: assert property (!sec_q && readback_req_i
		|=> readback_valid_o && readback_data_o == $past(array_pattern_i))
		else $error("Allowed readback not returned.");
	cmb_low_a: assert property (gsel == PLMC_GSEL_CMB && !local_cell_select_i[2] && !polarity_high_i[2]
		|=> pin_o[2] == !$past(sop_i[2]))
		else $error("Active-low combinatorial output wrong.");
	cio_enable_a: assert property (gsel == PLMC_GSEL_IO |=> pin_oe_o == $past(oe_term_i))
		else $error("Combinatorial I/O enable not from product term.");
	cio_feedback_a: assert property (gsel == PLMC_GSEL_IO |=> feedback_o == $past(pin_i))
		else $error("Combinatorial I/O feedback not from pin.");

	// Covers show that the bench reaches each main scenario.

	preload_c: cover property (preload_i ##1 !preload_i);
	secure_c: cover property (sec_q && readback_req_i);
	erase_c: cover property (sec_q && erase_i);
	input_c: cover property (gsel == PLMC_GSEL_CMB && local_cell_select_i != '0);
	reg_mode_c: cover property (gsel == PLMC_GSEL_REG && local_cell_select_i != '1);
endmodule

// ==== rtl/plmc_pkg.sv ====
// Purpose: Shared constants for the configurable output macrocell block.
// Assumes: Eight macrocells and a 64-bit signature word.
// Notes: Global and local select codes follow the configuration table.
package plmc_pkg;
	localparam int unsigned PLMC_CELLS = 8;
	localparam int unsigned PLMC_SIG_W = 64;
	// Cells that lose array feedback in plain combinatorial output mode.
	localparam logic [PLMC_CELLS-1:0] PLMC_NOFB_MASK = 8'h18;
	localparam logic [1:0] PLMC_GSEL_REG = 2'h2;
	localparam logic [1:0] PLMC_GSEL_CMB = 2'h1;
	localparam logic [1:0] PLMC_GSEL_IO = 2'h3;
	localparam logic PLMC_FF_RESET = 1'h0;
	localparam logic PLMC_SEC_CLEAR = 1'h0;
	localparam logic [PLMC_SIG_W-1:0] PLMC_SIG_RESET = 64'h0;
	typedef enum logic [1:0] {
		PLMC_MODE_REG,
		PLMC_MODE_CIO,
		PLMC_MODE_COUT,
		PLMC_MODE_IN
	} plmc_mode_t;
endpackage

// ==== testbench/plmc_board_model.sv ====
// Purpose: Board and tester side of the macrocell pins.
// Assumes: A pin released by its cell carries the level the tester puts on it.
// Notes: The tester level is fresh each cycle, so a released pin never keeps a stale value.
`timescale 1ns/1ps
module plmc_board_model
	import plmc_pkg::*;
(
	input wire logic [PLMC_CELLS-1:0] cell_out_i,
	input wire logic [PLMC_CELLS-1:0] cell_oe_i,
	input wire logic [PLMC_CELLS-1:0] tester_i,
	output logic [PLMC_CELLS-1:0] pin_o
);
	assign pin_o = (cell_oe_i & cell_out_i) | (~cell_oe_i & tester_i);
endmodule

// ==== testbench/test_plmc_macrocells.sv ====
// Purpose: Self-checking bench for the macrocell block.
// Assumes: Protection bit and signature start unknown, so the first step erases and writes them.
// Notes: The driver queues expected outputs; a monitor compares them one edge later.
`timescale 1ns/1ps
module test_plmc_macrocells
	import plmc_pkg::*;
;
	typedef struct {logic [7:0] po, pm, oe, cm, rd, fb; logic sc, rv; logic [63:0] sg;} plmc_note_t;
	plmc_note_t q[$];
	plmc_note_t mn;
	logic clk_sys_i = 1'h0, rst_n_i = 1'h0, lo = 1'h0, hi = 1'h0, oen = 1'h1, prl = 1'h0, ers = 1'h0;
	logic prg = 1'h0, sw = 1'h0, rq = 1'h0, msc, sc, rv;
	logic [7:0] loc = 8'h00, pol = 8'h00, sop = 8'h00, oet = 8'h00, brd = 8'h00, pat = 8'h00;
	logic [7:0] pin, po, oe, fv, rd, fbk, ep = 8'h00, eo = 8'h00;
	logic [63:0] sd = 64'h0, sg, msg;
	logic [31:0] rs = 32'h5a56, cr;
	int mismatches = 0, compares = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	plmc_macrocells plmc_macrocells_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .global_select_lo_i(lo),
		.global_select_hi_i(hi), .local_cell_select_i(loc), .polarity_high_i(pol), .sop_i(sop), .oe_term_i(oet),
		.oe_n_i(oen), .pin_i(pin), .preload_i(prl), .erase_i(ers), .prog_secure_i(prg), .sig_write_i(sw),
		.sig_data_i(sd), .readback_req_i(rq), .array_pattern_i(pat), .pin_o(po), .pin_oe_o(oe), .feedback_o(fbk),
		.feedback_valid_o(fv), .secure_o(sc), .readback_valid_o(rv), .readback_data_o(rd), .sig_o(sg));
	plmc_board_model plmc_board_model_i (.cell_out_i(po), .cell_oe_i(oe), .tester_i(brd), .pin_o(pin));
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic step(input logic r, input logic [1:0] g, input logic [5:0] c);
		plmc_note_t n;
		logic [7:0] cb, ff, rg, cio, co, pl;
		logic [31:0] x;
		@(posedge clk_sys_i);
		#1;
		x = xs();
		sop = c[5] ? 8'h00 : x[7:0];
		{pol, loc, oet} = x[31:8];
		x = xs();
		{brd, pat, oen} = x[16:0];
		sd = {x, ~x};
		{lo, hi} = g;
		{prl, ers, prg, sw, rq} = c[4:0];
		rst_n_i = r;
		// The preloaded state is the pin level, which a driving cell overrides.
		pl = (eo & ep) | (~eo & brd);
		ff = !r ? 8'h00 : (prl ? pl : sop);
		cb = ~(pol ^ sop);
		rg = (g == 2'h1) ? ~loc : 8'h00;
		cio = (g == 2'h1) ? loc : ((g == 2'h3) ? 8'hff : 8'h00);
		co = (g == 2'h2) ? ~loc : 8'h00;
		n.po = (rg & ~ff) | (~rg & cb);
		n.pm = rg | cio | co;
		n.oe = (rg & {8{~oen}}) | (cio & oet) | co;
		n.cm = co;
		n.fb = (rg & ff) | (co & ~PLMC_NOFB_MASK & cb) | (~rg & ~co & pl);
		n.rv = r & rq & ~msc;
		n.rd = n.rv ? pat : 8'h00;
		msc = ers ? 1'h0 : (prg ? 1'h1 : msc);
		msg = sw ? sd : msg;
		n.sc = msc;
		n.sg = msg;
		ep = n.po;
		eo = n.oe;
		q.push_back(n);
	endtask
	always @(posedge clk_sys_i) begin
		#0.5;
		if (q.size() > 0) begin
			mn = q.pop_front();
			compares++;
			if ((po & mn.pm) !== (mn.po & mn.pm) || oe !== mn.oe
				|| (fv & mn.cm) !== (~PLMC_NOFB_MASK & mn.cm) || fbk !== mn.fb
				|| sc !== mn.sc || rv !== mn.rv || rd !== mn.rd || sg !== mn.sg) begin
				mismatches++;
				$display("CHECK FAILED at %0t: outputs differ from expected", $time);
			end
		end
	end
	task automatic final_report();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		step(1'h1, 2'h1, 6'h2a);
		for (int g = 0; g < 4; g++) begin
			repeat (40) begin
				cr = xs();
				step(1'h1, g[1:0], {1'h0, cr[1:0] == 2'h0, cr[4:2] == 3'h0, cr[7:5] == 3'h0, cr[8], cr[9]});
			end
		end
		step(1'h0, 2'h1, 6'h00);
		step(1'h0, 2'h1, 6'h00);
		step(1'h1, 2'h1, 6'h20);
		repeat (3) @(posedge clk_sys_i);
		final_report();
	end
	// The run needs about two hundred cycles; this limit leaves ample slack.
	initial begin
		#10000;
		mismatches++;
		final_report();
	end
endmodule
